/* File: core_pkg.sv */
package core_pkg;
	// Fixed whole-word codes
	localparam logic [13:0] OP_EMPTY      = 14'h0000;
	localparam logic [13:0] OP_SOFT_RST   = 14'h0001;
	localparam logic [13:0] OP_SUB_EXIT   = 14'h0008;
	localparam logic [13:0] OP_IRQ_EXIT   = 14'h0009;
	localparam logic [13:0] OP_SUB_JACC   = 14'h000A;
	localparam logic [13:0] OP_REL_JACC   = 14'h000B;
	localparam logic [13:0] OP_HALT       = 14'h0063;
	localparam logic [13:0] OP_DOG_KICK   = 14'h0064;
	// Prefix codes, compared against the top bits
	localparam logic [10:0] PFX_PIN_DIR   = 11'h00C;
	localparam logic [10:0] PFX_LOAD_IND  = 11'h002;
	localparam logic [10:0] PFX_STORE_IND = 11'h003;
	localparam logic [6:0]  PFX_PTR_ADD   = 7'h62;
	localparam logic [5:0]  PFX_EXIT_LIT  = 6'h34;
	localparam logic [5:0]  PFX_AND_LIT   = 6'h39;
	localparam logic [5:0]  PFX_ADD_LIT   = 6'h3E;
	localparam logic [5:0]  PFX_INDEXED   = 6'h3F;
	localparam logic [5:0]  PFX_AND_FILE  = 6'h05;
	localparam logic [4:0]  PFX_REL_JUMP  = 5'h19;
	localparam logic [2:0]  PFX_SUB_JUMP  = 3'h4;
	localparam logic [2:0]  PFX_ABS_JUMP  = 3'h5;
	// Indirect window addresses in file space
	localparam logic [6:0]  WIN0_ADDR     = 7'h00;
	localparam logic [6:0]  WIN1_ADDR     = 7'h01;
	// Status flag positions and reset value
	localparam int          FLAG_CARRY    = 0;
	localparam int          FLAG_NIBBLE   = 1;
	localparam int          FLAG_ZERO     = 2;
	localparam int          FLAG_TIMEOUT  = 3;
	localparam int          FLAG_PWRDOWN  = 4;
	localparam logic [4:0]  FLAGS_RST     = 5'h18;
	// Extra cycles
	localparam logic [1:0]  JUMP_EXTRA    = 2'h1;
	localparam logic [1:0]  IND_EXTRA     = 2'h1;
	// APB byte offsets, control bit positions and direction reset value
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_ACC       = 8'h08;
	localparam logic [7:0]  OFS_PTR0      = 8'h0C;
	localparam logic [7:0]  OFS_PTR1      = 8'h10;
	localparam logic [7:0]  OFS_COUNTER   = 8'h14;
	localparam logic [7:0]  OFS_DIR_LO    = 8'h18;
	localparam logic [7:0]  OFS_DIR_HI    = 8'h1C;
	localparam int          CTRL_RUN      = 0;
	localparam int          CTRL_WAKE     = 1;
	localparam logic [7:0]  DIR_RST       = 8'hFF;
endpackage

/* File: instr_core.sv */
`timescale 1ns/1ps
module instr_core (
	input  wire logic        pclk,       // Core clock
	input  wire logic        presetn,    // Async reset, active low
	input  wire logic        psel,       // APB select
	input  wire logic        penable,    // APB enable
	input  wire logic        pwrite,     // APB direction
	input  wire logic [7:0]  paddr,      // APB byte address
	input  wire logic [31:0] pwdata,     // APB write data
	output logic      [31:0] prdata,     // APB read data
	output logic             pready,     // APB ready
	output logic             pslverr,    // APB error, unmapped
	output logic      [14:0] pm_addr,    // Program memory address
	input  wire logic [13:0] pm_data,    // Instruction word
	output logic      [63:0] pin_dir,    // Eight pin direction regs
	output logic             standby,    // Core halted
	output logic             dog_kick,   // Watchdog restart pulse
	output logic             soft_reset  // Software restart pulse
);
	logic [7:0]  acc_q, acc_d;
	logic [15:0] ptr_q [2];
	logic [15:0] ptr_d [2];
	logic [14:0] pgm_ctr_q, pgm_ctr_d;
	logic [4:0]  flags_q, flags_d;
	logic [14:0] stack_q [16];
	logic [3:0]  sp_q, sp_d;
	logic        push, pop;
	logic [7:0]  dmem_q [128];
	logic        mem_we;
	logic [6:0]  mem_addr;
	logic [7:0]  mem_wdata, mem_rd;
	logic [7:0]  dir_q [8];
	logic        dir_we;
	logic [1:0]  wait_q, wait_d;
	logic        run_q, halt_d, dog_d, srst_d;
	logic        exec;
	logic [13:0] op;
	logic        bus_wr;

	typedef enum {RUNNING, HALTED} core_state_t;
	core_state_t state_q, state_d;

	// Sign-extend a 6-bit literal to pointer width
	function automatic logic [15:0] sext6(input logic [5:0] k);
		sext6 = {{10{k[5]}}, k};
	endfunction

	// Zero test shared by every op that sets the zero flag
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction

	assign op = pm_data;
	assign exec = run_q && (state_q == RUNNING) && (wait_q == 2'h0);
	assign mem_rd = dmem_q[mem_addr];
	assign bus_wr = psel && penable && pready && pwrite;

	// Decode and execute; the next value of every core register
	always_comb
	begin
		logic [8:0]  sum;
		logic [4:0]  nib;
		logic        n;
		logic [15:0] p;
		logic [7:0]  fval;
		sum = 9'h000;
		nib = 5'h00;
		n = 1'b0;
		p = 16'h0000;
		fval = 8'h00;
		acc_d = acc_q;
		ptr_d = ptr_q;
		pgm_ctr_d = pgm_ctr_q;
		flags_d = flags_q;
		sp_d = sp_q;
		push = 1'b0;
		pop = 1'b0;
		mem_we = 1'b0;
		mem_addr = op[6:0];
		mem_wdata = 8'h00;
		dir_we = 1'b0;
		wait_d = (wait_q != 2'h0) ? wait_q - 2'h1 : 2'h0;
		state_d = state_q;
		halt_d = 1'b0;
		dog_d = 1'b0;
		srst_d = 1'b0;
		if (exec)
		begin
			pgm_ctr_d = pgm_ctr_q + 15'h0001;
			if (op == core_pkg::OP_EMPTY)
			begin
				// Nothing changes but the counter
			end
			else if (op == core_pkg::OP_SOFT_RST)
			begin
				srst_d = 1'b1;
				pgm_ctr_d = 15'h0000;
			end
			else if (op == core_pkg::OP_SUB_EXIT
				|| op == core_pkg::OP_IRQ_EXIT)
			begin
				pop = 1'b1;
				sp_d = sp_q - 4'h1;
				pgm_ctr_d = stack_q[sp_q - 4'h1];
				wait_d = core_pkg::JUMP_EXTRA;
			end
			else if (op == core_pkg::OP_SUB_JACC)
			begin
				push = 1'b1;
				sp_d = sp_q + 4'h1;
				pgm_ctr_d = {pgm_ctr_q[14:8], acc_q};
				wait_d = core_pkg::JUMP_EXTRA;
			end
			else if (op == core_pkg::OP_REL_JACC)
			begin
				pgm_ctr_d = pgm_ctr_q + 15'h0001 + {7'h00, acc_q};
				wait_d = core_pkg::JUMP_EXTRA;
			end
			else if (op == core_pkg::OP_HALT)
			begin
				// Halt enters standby in its own single cycle
				flags_d[core_pkg::FLAG_TIMEOUT] = 1'b1;
				flags_d[core_pkg::FLAG_PWRDOWN] = 1'b0;
				state_d = HALTED;
				halt_d = 1'b1;
			end
			else if (op == core_pkg::OP_DOG_KICK)
			begin
				flags_d[core_pkg::FLAG_TIMEOUT] = 1'b1;
				flags_d[core_pkg::FLAG_PWRDOWN] = 1'b1;
				dog_d = 1'b1;
			end
			else if (op[13:3] == core_pkg::PFX_PIN_DIR)
			begin
				dir_we = 1'b1;
			end
			else if (op[13:3] == core_pkg::PFX_LOAD_IND
				|| op[13:3] == core_pkg::PFX_STORE_IND)
			begin
				// Pre forms adjust before the access, post forms after
				n = op[2];
				p = ptr_q[n];
				case (op[1:0])
					2'h0: p = p + 16'h0001;
					2'h1: p = p - 16'h0001;
					default: p = p;
				endcase
				mem_addr = p[6:0];
				if (op[1:0] == 2'h2)
					ptr_d[n] = p + 16'h0001;
				else if (op[1:0] == 2'h3)
					ptr_d[n] = p - 16'h0001;
				else
					ptr_d[n] = p;
				if (op[3])
				begin
					mem_we = 1'b1;
					mem_wdata = acc_q;
				end
				else
				begin
					acc_d = mem_rd;
					flags_d[core_pkg::FLAG_ZERO] = is_zero(mem_rd);
				end
				if (p[15])
					wait_d = core_pkg::IND_EXTRA;
			end
			else if (op[13:7] == core_pkg::PFX_PTR_ADD)
			begin
				// Wraps with no saturation; flags untouched
				ptr_d[op[6]] = ptr_q[op[6]] + sext6(op[5:0]);
			end
			else if (op[13:8] == core_pkg::PFX_INDEXED)
			begin
				n = op[6];
				p = ptr_q[n] + sext6(op[5:0]);
				mem_addr = p[6:0];
				if (op[7])
				begin
					mem_we = 1'b1;
					mem_wdata = acc_q;
				end
				else
				begin
					acc_d = mem_rd;
					flags_d[core_pkg::FLAG_ZERO] = is_zero(mem_rd);
				end
				if (ptr_q[n][15])
					wait_d = core_pkg::IND_EXTRA;
			end
			else if (op[13:8] == core_pkg::PFX_EXIT_LIT)
			begin
				acc_d = op[7:0];
				pop = 1'b1;
				sp_d = sp_q - 4'h1;
				pgm_ctr_d = stack_q[sp_q - 4'h1];
				wait_d = core_pkg::JUMP_EXTRA;
			end
			else if (op[13:8] == core_pkg::PFX_AND_LIT)
			begin
				acc_d = acc_q & op[7:0];
				flags_d[core_pkg::FLAG_ZERO] = is_zero(acc_q & op[7:0]);
			end
			else if (op[13:8] == core_pkg::PFX_ADD_LIT)
			begin
				sum = {1'b0, acc_q} + {1'b0, op[7:0]};
				nib = {1'b0, acc_q[3:0]} + {1'b0, op[3:0]};
				acc_d = sum[7:0];
				flags_d[core_pkg::FLAG_CARRY] = sum[8];
				flags_d[core_pkg::FLAG_NIBBLE] = nib[4];
				flags_d[core_pkg::FLAG_ZERO] = is_zero(sum[7:0]);
			end
			else if (op[13:8] == core_pkg::PFX_AND_FILE)
			begin
				// Window addresses go through their pointer
				if (op[6:0] == core_pkg::WIN0_ADDR
					|| op[6:0] == core_pkg::WIN1_ADDR)
				begin
					mem_addr = ptr_q[op[0]][6:0];
					if (ptr_q[op[0]][15])
						wait_d = core_pkg::IND_EXTRA;
				end
				fval = acc_q & mem_rd;
				if (op[7])
				begin
					mem_we = 1'b1;
					mem_wdata = fval;
				end
				else
					acc_d = fval;
				flags_d[core_pkg::FLAG_ZERO] = is_zero(fval);
			end
			else if (op[13:9] == core_pkg::PFX_REL_JUMP)
			begin
				pgm_ctr_d = pgm_ctr_q + 15'h0001
					+ {{6{op[8]}}, op[8:0]};
				wait_d = core_pkg::JUMP_EXTRA;
			end
			else if (op[13:11] == core_pkg::PFX_SUB_JUMP)
			begin
				push = 1'b1;
				sp_d = sp_q + 4'h1;
				pgm_ctr_d = {pgm_ctr_q[14:11], op[10:0]};
				wait_d = core_pkg::JUMP_EXTRA;
			end
			else if (op[13:11] == core_pkg::PFX_ABS_JUMP)
			begin
				pgm_ctr_d = {pgm_ctr_q[14:11], op[10:0]};
				wait_d = core_pkg::JUMP_EXTRA;
			end
		end
		else if (state_q == HALTED && pwdata[core_pkg::CTRL_WAKE]
			&& bus_wr && paddr == core_pkg::OFS_CTRL)
			state_d = RUNNING;
	end

	// Core state; software writes to the accumulator win
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_q <= 8'h00;
			pgm_ctr_q <= 15'h0000;
			flags_q <= core_pkg::FLAGS_RST;
			sp_q <= 4'h0;
			wait_q <= 2'h0;
			state_q <= RUNNING;
		end
		else
		begin
			acc_q <= (bus_wr && paddr == core_pkg::OFS_ACC) ?
				pwdata[7:0] : acc_d;
			pgm_ctr_q <= pgm_ctr_d;
			flags_q <= flags_d;
			sp_q <= sp_d;
			wait_q <= wait_d;
			state_q <= state_d;
		end
	end

	// Pointer pairs; bus write has priority over the core
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ptr_q[0] <= 16'h0000;
			ptr_q[1] <= 16'h0000;
		end
		else
		begin
			ptr_q[0] <= (bus_wr && paddr == core_pkg::OFS_PTR0) ?
				pwdata[15:0] : ptr_d[0];
			ptr_q[1] <= (bus_wr && paddr == core_pkg::OFS_PTR1) ?
				pwdata[15:0] : ptr_d[1];
		end
	end

	// Return stack and data memory hold no reset; contents are undefined
	always_ff @(posedge pclk)
	begin
		if (push)
			stack_q[sp_q] <= pgm_ctr_q + 15'h0001;
		if (mem_we)
			dmem_q[mem_addr] <= mem_wdata;
	end

	// Pin direction registers come up as inputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 8; i++)
				dir_q[i] <= core_pkg::DIR_RST;
		end
		else if (dir_we)
			dir_q[op[2:0]] <= acc_q;
	end

	// Registered side outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			standby <= 1'b0;
			dog_kick <= 1'b0;
			soft_reset <= 1'b0;
			pin_dir <= {8{core_pkg::DIR_RST}};
		end
		else
		begin
			standby <= (state_d == HALTED);
			dog_kick <= dog_d;
			soft_reset <= srst_d;
			pin_dir <= {dir_q[7], dir_q[6], dir_q[5], dir_q[4],
				dir_q[3], dir_q[2], dir_q[1], dir_q[0]};
		end
	end

	assign pm_addr = pgm_ctr_q;

	// Run control bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_q <= 1'b0;
		else if (bus_wr && paddr == core_pkg::OFS_CTRL)
			run_q <= pwdata[core_pkg::CTRL_RUN];
	end

	// APB slave: answer prepared in setup, ready in first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable)
			begin
				case (paddr)
					core_pkg::OFS_CTRL:
						prdata <= {31'h0, run_q};
					core_pkg::OFS_STATUS:
						prdata <= {24'h0, (wait_q != 2'h0),
							(state_q == HALTED), sp_q == 4'h0, flags_q};
					core_pkg::OFS_ACC:
						prdata <= {24'h0, acc_q};
					core_pkg::OFS_PTR0:
						prdata <= {16'h0, ptr_q[0]};
					core_pkg::OFS_PTR1:
						prdata <= {16'h0, ptr_q[1]};
					core_pkg::OFS_COUNTER:
						prdata <= {17'h0, pgm_ctr_q};
					core_pkg::OFS_DIR_LO:
						prdata <= {dir_q[3], dir_q[2], dir_q[1], dir_q[0]};
					core_pkg::OFS_DIR_HI:
						prdata <= {dir_q[7], dir_q[6], dir_q[5], dir_q[4]};
					default:
						pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule

/* File: prog_rom.sv */
`timescale 1ns/1ps
module prog_rom (
	input  wire logic [14:0] addr, // Fetch address
	output logic      [13:0] data  // Word, same cycle
);
	logic [13:0] rom [0:31];

	// Only 32 words decoded, so upper addresses alias onto them
	assign data = rom[addr[4:0]];

	// Unloaded words read as the empty cycle
	initial
		for (int i = 0; i < 32; i++)
			rom[i] = 14'h0000;
endmodule

/* File: instr_core_chk.sv */
`timescale 1ns/1ps
module instr_core_chk (
	input wire logic        pclk,       // Clock
	input wire logic        presetn,    // Reset, active low
	input wire logic        psel,       // Select
	input wire logic        penable,    // Enable
	input wire logic        pwrite,     // Direction
	input wire logic [7:0]  paddr,      // Address
	input wire logic [31:0] pwdata,     // Write data
	input wire logic [31:0] prdata,     // Read data
	input wire logic        pready,     // Ready
	input wire logic        pslverr,    // Error
	input wire logic [14:0] pm_addr,    // Counter
	input wire logic [13:0] pm_data,    // Instruction
	input wire logic [63:0] pin_dir,    // Direction regs
	input wire logic        standby,    // Halted
	input wire logic        dog_kick,   // Kick pulse
	input wire logic        soft_reset  // Restart pulse
);
	logic [10:0] op_pfx;

	// Slice first, since $past takes a plain signal
	assign op_pfx = pm_data[13:3];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Counter moved off sequence; a restart is not a jump
	sequence jump_s;
		!soft_reset && $changed(pm_addr)
			&& pm_addr != $past(pm_addr) + 15'h1;
	endsequence
	sequence idle_s;
		$stable(pm_addr);
	endsequence

	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	jump_idle_a: assert property (jump_s |=> idle_s)
		else $error("no idle cycle after jump");
	halt_cause_a: assert property ($rose(standby) |->
		$past(pm_data) == core_pkg::OP_HALT)
		else $error("standby without halt");
	halted_quiet_a: assert property (standby |-> !dog_kick)
		else $error("activity while halted");
	kick_cause_a: assert property (dog_kick |->
		$past(pm_data) == core_pkg::OP_DOG_KICK)
		else $error("kick without its op");
	kick_pulse_a: assert property (dog_kick |=> !dog_kick)
		else $error("kick longer than one cycle");
	dir_cause_a: assert property ($changed(pin_dir) |->
		$past(op_pfx, 2) == core_pkg::PFX_PIN_DIR)
		else $error("direction change without its op");
endmodule

bind instr_core instr_core_chk chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pm_addr(pm_addr), .pm_data(pm_data),
	.pin_dir(pin_dir), .standby(standby), .dog_kick(dog_kick),
	.soft_reset(soft_reset));

/* File: test_instr_core.sv */
`timescale 1ns/1ps
module test_instr_core;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [14:0] pm_addr;
	logic [13:0] pm_data;
	logic [63:0] pin_dir;
	logic        standby;
	logic        dog_kick;
	logic        soft_reset;
	logic [31:0] rd;
	logic        er;
	int          error_cnt;
	int          tests_run;
	int          kicks;

	instr_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pm_addr(pm_addr), .pm_data(pm_data),
		.pin_dir(pin_dir), .standby(standby), .dog_kick(dog_kick),
		.soft_reset(soft_reset));
	prog_rom mem (.addr(pm_addr), .data(pm_data));

	// Core clock
	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	// Pulses are counted, since one is easily missed by polling
	always @(posedge pclk)
		if (dog_kick === 1'b1)
			kicks++;

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
			error_cnt++;
		end
	endtask

	// One transfer; reads at the edge see values before that edge lands
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees ready
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, rd & mask, exp);
	endtask

	// Start or wake the core and wait for it to halt again
	task automatic run_to_halt(input logic [31:0] ctrl);
		int n;
		apb(1'b1, core_pkg::OFS_CTRL, ctrl);
		n = 0;
		while (standby === 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		while (standby !== 1'b1 && n < 200)
		begin
			@(posedge pclk);
			n++;
		end
		check("standby", {31'h0, standby}, 32'h1);
	endtask

	task automatic reset_values;
		rd_chk("flags", core_pkg::OFS_STATUS, 32'h1F, 32'h18);
		rd_chk("dir lo", core_pkg::OFS_DIR_LO, 32'hFFFFFFFF, 32'hFFFFFFFF);
		rd_chk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
		check("unmapped err", {31'h0, er}, 32'h1);
		$display("reset values done");
	endtask

	task automatic literal_pointer;
		mem.rom[0] = 14'h393C;
		mem.rom[1] = 14'h3EF4;
		mem.rom[2] = 14'h313F;
		mem.rom[3] = core_pkg::OP_HALT;
		apb(1'b1, core_pkg::OFS_ACC, 32'h0F);
		apb(1'b1, core_pkg::OFS_PTR0, 32'h0);
		run_to_halt(32'h1);
		rd_chk("acc", core_pkg::OFS_ACC, 32'hFF, 32'h00);
		rd_chk("ptr0", core_pkg::OFS_PTR0, 32'hFFFF, 32'hFFFF);
		rd_chk("flags", core_pkg::OFS_STATUS, 32'h1F, 32'h0F);
		$display("literal and pointer ops done");
	endtask

	task automatic indirect_ops;
		int k0;
		mem.rom[4] = 14'h0065;
		mem.rom[5] = 14'h001E;
		mem.rom[6] = 14'h3900;
		mem.rom[7] = 14'h3F7F;
		mem.rom[8] = core_pkg::OP_DOG_KICK;
		mem.rom[9] = 14'h280C;
		mem.rom[10] = 14'h3900;
		mem.rom[11] = 14'h3900;
		mem.rom[12] = core_pkg::OP_HALT;
		apb(1'b1, core_pkg::OFS_ACC, 32'hA5);
		apb(1'b1, core_pkg::OFS_PTR1, 32'h10);
		k0 = kicks;
		run_to_halt(32'h3);
		check("dir 5", {24'h0, pin_dir[47:40]}, 32'hA5);
		rd_chk("acc", core_pkg::OFS_ACC, 32'hFF, 32'hA5);
		rd_chk("ptr1", core_pkg::OFS_PTR1, 32'hFFFF, 32'h11);
		rd_chk("flags", core_pkg::OFS_STATUS, 32'h1F, 32'h0B);
		check("kicks", 32'(kicks - k0), 32'h1);
		$display("indirect ops done");
	endtask

	// Call, return with literal, file AND to memory, relative jump
	task automatic control_flow;
		mem.rom[13] = 14'h2014;
		mem.rom[14] = 14'h0590;
		mem.rom[15] = 14'h3202;
		mem.rom[16] = 14'h3900;
		mem.rom[17] = 14'h3900;
		mem.rom[18] = core_pkg::OP_HALT;
		mem.rom[20] = 14'h345A;
		run_to_halt(32'h3);
		check("counter", {17'h0, pm_addr}, 32'h13);
		rd_chk("acc", core_pkg::OFS_ACC, 32'hFF, 32'h5A);
		rd_chk("flags", core_pkg::OFS_STATUS, 32'h3F, 32'h2F);
		$display("control flow done");
	endtask

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog, well beyond the hundred or so cycles the tests take
	initial
	begin
		repeat (3000) @(posedge pclk);
		error_cnt++;
		end_of_test;
	end

	initial
	begin
		error_cnt = 0;
		tests_run = 0;
		kicks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		reset_values;
		literal_pointer;
		indirect_ops;
		control_flow;
		end_of_test;
	end
endmodule
